// ===== icr_pkg.sv
// Package for the isolator channel refresh/watchdog block.
// Assumes a single 250 MHz system clock; times are given in ns.
package icr_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned PULSE_WIDTH_NS  = 1;     // Barrier pulse width
  localparam int unsigned REFRESH_NS      = 1000;  // Idle time before refresh
  localparam int unsigned WATCHDOG_NS     = 5000;  // No-pulse timeout
  localparam int unsigned RESUME_NS       = 1000;  // Resume bound after power returns

  // Least times round up, none below one cycle
  localparam int unsigned PULSE_CYC   = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Refresh must fire at or before the bound, so round down
  localparam int unsigned REFRESH_CYC = REFRESH_NS / CLK_PERIOD_NS;
  localparam int unsigned WATCHDOG_CYC = (WATCHDOG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESUME_CYC  = RESUME_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Barrier pulse kinds
  typedef enum logic [1:0] {
    ICR_PULSE_NONE,
    ICR_PULSE_SET,
    ICR_PULSE_RESET
  } icr_pulse_e;

  // Output mode
  localparam logic [1:0] ICR_OUT_PASS    = 2'h0;
  localparam logic [1:0] ICR_OUT_DEFAULT = 2'h1;
  localparam logic [1:0] ICR_OUT_HIZ     = 2'h2;

  localparam logic RESET_LEVEL = 1'b0;

endpackage

// ===== icr_encoder.sv
// Input-side encoder: turns input edges and idle refreshes into barrier pulses.
// Assumes channel_input is synchronous to clk_sys.
`timescale 1ns/10ps
module icr_encoder
  import icr_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Input side
  input  wire logic       channel_input,
  input  wire logic       enc_enable,
  // Barrier
  output icr_pulse_e      pulse_kind
);

  // Elaboration check: the idle counter needs at least two states
  if (REFRESH_CYCLES < 2) begin : g_bad_refresh
    $error("REFRESH_CYCLES too small");
  end

  localparam int unsigned CW = $clog2(REFRESH_CYCLES + 1);

  typedef struct packed {
    logic          last_in;
    logic          armed;
    logic [CW-1:0] idle_cnt;
    icr_pulse_e    pulse;
  } icr_enc_s;

  icr_enc_s st_q, st_d;

  // ==========================================================================
  // Edge and refresh pulse generation
  always_comb begin
    st_d       = st_q;
    st_d.pulse = ICR_PULSE_NONE;
    if (!enc_enable) begin
      // Disabled or unpowered: no pulses, so the far watchdog times out
      st_d.armed    = 1'b0;
      st_d.idle_cnt = '0;
    end else if (!st_q.armed || channel_input != st_q.last_in) begin
      // One pulse per edge; first pulse after enable gives level at once
      st_d.pulse    = channel_input ? ICR_PULSE_SET : ICR_PULSE_RESET;
      st_d.last_in  = channel_input;
      st_d.armed    = 1'b1;
      st_d.idle_cnt = '0;
    end else if (st_q.idle_cnt == CW'(REFRESH_CYCLES - 1)) begin
      // Idle too long: resend current level
      st_d.pulse    = channel_input ? ICR_PULSE_SET : ICR_PULSE_RESET;
      st_d.idle_cnt = '0;
    end else begin
      st_d.idle_cnt = st_q.idle_cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{last_in: RESET_LEVEL, armed: 1'b0, idle_cnt: '0, pulse: ICR_PULSE_NONE};
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse_kind = st_q.pulse;

endmodule

// ===== icr_channel.sv
// One isolator channel: encoder, bistable decoder, watchdog and output control.
// Assumes all pins sampled synchronous to clk_sys; supplies given as power-good levels.
`timescale 1ns/10ps
module icr_channel
  import icr_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES  = REFRESH_CYC,
  parameter int unsigned WATCHDOG_CYCLES = WATCHDOG_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Input side
  input  wire logic channel_input,
  input  wire logic input_block_control,
  input  wire logic input_side_supply,
  // Output side
  input  wire logic default_level_select,
  input  wire logic output_side_supply,
  output logic      channel_output,
  output logic      channel_output_oe,
  output logic      watchdog_expired
);

  // Elaboration checks: a watchdog shorter than refresh would fire on an idle line
  if (WATCHDOG_CYCLES <= REFRESH_CYCLES) begin : g_bad_watchdog
    $error("Watchdog must exceed refresh interval");
  end
  if (REFRESH_CYCLES > RESUME_CYC) begin : g_bad_resume
    $error("Refresh interval breaks resume bound");
  end

  localparam int unsigned WW = $clog2(WATCHDOG_CYCLES + 1);

  // ==========================================================================
  // Encoder on the input side
  icr_pulse_e pulse_kind;
  logic       enc_enable;

  // Disable pin blocks inputs; unpowered side sends nothing
  assign enc_enable = input_side_supply && !input_block_control;

  icr_encoder #(
    .REFRESH_CYCLES (REFRESH_CYCLES)
  ) u_encoder (
    .clk_sys       (clk_sys),
    .resetn        (resetn),
    .channel_input (channel_input),
    .enc_enable    (enc_enable),
    .pulse_kind    (pulse_kind)
  );

  // ==========================================================================
  // Output-side state
  typedef struct packed {
    logic          latch;     // Bistable decoder
    logic          timed_out; // Watchdog has fired
    logic [WW-1:0] wd_cnt;
    logic          out;
    logic          oe;
  } icr_out_s;

  icr_out_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    // Decoder holds between pulses; the watchdog reloads on any pulse
    unique case (pulse_kind)
      ICR_PULSE_SET: begin
        st_d.latch     = 1'b1;
        st_d.wd_cnt    = '0;
        st_d.timed_out = 1'b0;
      end
      ICR_PULSE_RESET: begin
        st_d.latch     = 1'b0;
        st_d.wd_cnt    = '0;
        st_d.timed_out = 1'b0;
      end
      ICR_PULSE_NONE: begin
        if (st_q.wd_cnt == WW'(WATCHDOG_CYCLES - 1)) begin
          st_d.timed_out = 1'b1;
        end else begin
          st_d.wd_cnt = st_q.wd_cnt + WW'(1);
        end
      end
      default: begin
        st_d.timed_out = st_q.timed_out;
      end
    endcase

    // Output mux; select only matters once the watchdog has fired
    // Disable and dead input both starve pulses, so both land on default
    if (!output_side_supply) begin
      st_d.oe  = 1'b0;
      st_d.out = 1'b0;
    end else if (st_d.timed_out) begin
      st_d.oe  = 1'b1;
      st_d.out = default_level_select;
    end else begin
      st_d.oe  = 1'b1;
      st_d.out = st_d.latch;
    end
  end

  // Reset starts timed out so output shows default until the first pulse
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{latch: RESET_LEVEL, timed_out: 1'b1, wd_cnt: '0, out: RESET_LEVEL, oe: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign channel_output    = st_q.out;
  assign channel_output_oe = st_q.oe;
  assign watchdog_expired  = st_q.timed_out;

endmodule

// ===== icr_channel_asserts.sv
// Checker for one isolator channel, bound to icr_channel.
// Assumes the one clk_sys domain and the small timer values set by the bench.
`timescale 1ns/10ps
module icr_channel_asserts #(
  parameter int unsigned REFRESH_CYCLES  = 4,
  parameter int unsigned WATCHDOG_CYCLES = 10
) (
  input wire logic clk_sys, resetn, channel_input, input_block_control, input_side_supply,
  input wire logic default_level_select, output_side_supply, channel_output, channel_output_oe, watchdog_expired
);
  // ==========
  // Helpers
  logic        en, blk;
  logic [15:0] cnt_q;
  assign en  = input_side_supply && !input_block_control && output_side_supply;
  assign blk = !input_side_supply || input_block_control;
  // Blocked cycles, saturating so a long stall cannot wrap back to zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) cnt_q <= 16'h0;
    else cnt_q <= blk ? cnt_q + {15'h0, cnt_q != 16'hFFFF} : 16'h0;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  follow_input_a: assert property ((en && $stable(channel_input))[*4] |-> channel_output == channel_input)
    else $error("output does not follow input");
  quiet_watchdog_a: assert property (en[*6] |-> !watchdog_expired)
    else $error("watchdog fired while refreshed");
  hold_output_a: assert property (blk && cnt_q >= 3 && channel_output_oe && $past(channel_output_oe) && !watchdog_expired
    |-> $stable(channel_output))
    else $error("blocked input reached output");
  default_live_a: assert property (watchdog_expired && $past(watchdog_expired) && channel_output_oe
    |-> channel_output == $past(default_level_select))
    else $error("default level not shown");
  wd_expire_a: assert property (blk && output_side_supply && cnt_q > WATCHDOG_CYCLES + 3 |-> watchdog_expired)
    else $error("watchdog late");
  hiz_off_a: assert property (!output_side_supply |=> !channel_output_oe && !channel_output)
    else $error("output driven while unpowered");
  oe_on_a: assert property (output_side_supply |=> channel_output_oe)
    else $error("output not driven while powered");
  pulse_clears_a: assert property ($fell(watchdog_expired) |-> !blk || !$past(blk) || !$past(blk, 2) || !$past(blk, 3))
    else $error("watchdog cleared without pulse");
endmodule
bind icr_channel icr_channel_asserts #(.REFRESH_CYCLES(REFRESH_CYCLES), .WATCHDOG_CYCLES(WATCHDOG_CYCLES)) CHK (
  .clk_sys, .resetn, .channel_input, .input_block_control, .input_side_supply,
  .default_level_select, .output_side_supply, .channel_output, .channel_output_oe, .watchdog_expired);

// ===== icr_far_side.sv
// Far-side model: upstream logic driving the channel input, downstream pin.
// Assumes the bench hands over the next level away from the rising edge.
`timescale 1ns/10ps
module icr_far_side (
  input  wire logic clk_sys,
  input  wire logic next_level,
  input  wire logic channel_output,
  input  wire logic channel_output_oe,
  output logic      channel_input,
  output logic      pin_level
);
  logic hold_q = 1'b0;
  logic last_q = 1'b0;
  initial channel_input = 1'b0;
  // Upstream takes the level on the rise and drives it on the fall
  always @(posedge clk_sys) hold_q <= next_level;
  always @(negedge clk_sys) channel_input <= hold_q;
  // Released pin shows the inverse of its last level, so a stale value cannot pass
  always @(posedge clk_sys) if (channel_output_oe) last_q <= channel_output;
  assign pin_level = channel_output_oe ? channel_output : !last_q;
endmodule

// ===== icr_channel_bench.sv
// Bench for one isolator channel with small refresh and watchdog counts.
// Assumes the far-side model and the bound checker.
`timescale 1ns/10ps
module icr_channel_bench;
  localparam int unsigned RC = 4;
  localparam int unsigned WC = 10;
  logic clk_sys = 1'b0, resetn = 1'b0, nxt = 1'b0, blk = 1'b0, isup = 1'b1, sel = 1'b0, osup = 1'b1;
  logic chin, chout, oe, wdx, pin;
  logic [31:0] rs = 32'h3DDD;
  int n_errors = 0, n_checks = 0, cyc = 0;
  icr_channel #(.REFRESH_CYCLES(RC), .WATCHDOG_CYCLES(WC)) DUT (.clk_sys(clk_sys), .resetn(resetn),
    .channel_input(chin), .input_block_control(blk), .input_side_supply(isup), .default_level_select(sel),
    .output_side_supply(osup), .channel_output(chout), .channel_output_oe(oe), .watchdog_expired(wdx));
  icr_far_side FAR (.clk_sys(clk_sys), .next_level(nxt), .channel_output(chout), .channel_output_oe(oe),
    .channel_input(chin), .pin_level(pin));
  initial forever #2 clk_sys = ~clk_sys;
  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      complete_run;
    end
  end
  // ==========
  // Scenarios
  initial begin
    tick(8);
    resetn = 1'b1;
    for (int i = 0; i < 60; i++) begin
      rs = xs(rs);
      nxt = rs[0];
      sel = rs[1];
      tick(1 + rs[4:2]);
      if (rs[4:2] >= 5) chk(chout, nxt);
    end
    tick(40);
    chk(wdx, 1'b0);
    chk(chout, nxt);
    // Disable, then input side off, each with both default levels; input moves meanwhile
    for (int k = 0; k < 4; k++) begin
      sel = k[0];
      nxt = !nxt;
      blk = !k[1];
      isup = !k[1];
      tick(WC + 8);
      chk(wdx, 1'b1);
      chk(chout, sel);
      blk = 1'b0;
      isup = 1'b1;
      tick(6);
      chk(chout, nxt);
    end
    osup = 1'b0;
    tick(2);
    chk(oe, 1'b0);
    chk(pin, !nxt);
    osup = 1'b1;
    tick(6);
    chk(chout, nxt);
    // Second reset in mid-run
    sel = nxt;
    resetn = 1'b0;
    tick(2);
    chk(oe, 1'b0);
    resetn = 1'b1;
    tick(8);
    chk(chout, nxt);
    complete_run;
  end
endmodule
